// ===== logic/phy_mgmt_and_link_config.sv
// Operation
// - registers are 16-bit words, numbered 0 to 31, bits 0 to 15
// - two address straps select management address 0, 1, 28 or 29
// - with negotiation enabled, partner remote fault sets bit 5.13 and status bit 1.4
// - advertisement bit 4.13 carries the local remote fault to the partner
// - writing 1 to bit 26.11 raises the MII output drive strength
// - without forced mode, negotiate with pulse bursts, else parallel-detect
// - at 100 Mbps send MLT3 symbols continuously, idles between frames
// - at 10 Mbps Manchester data, idle line, periodic link pulses
// - MII rate follows the resolved link speed with negotiation enabled, else bit 0.13
// - transmit control field selects one of four slew rates
// - configuration straps set the defaults when management is unused
`timescale 1ns/1ns
module phy_mgmt_and_link_config (
    // clock, reset, enable
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       ce_i,
    // management pins
    input  wire logic       mdc_i,
    input  wire logic       mdio_i,
    output logic            mdio_o,
    output logic            mdio_oe_o,
    // straps
    input  wire logic [1:0] addr_strap_i,
    input  wire logic [2:0] cfg_strap_i,
    // link engine status
    input  wire logic       partner_rf_i,
    input  wire logic       resolved_valid_i,
    input  wire logic       resolved_speed100_i,
    // configuration to the line and MII logic
    output logic            mii_high_drive_o,
    output logic [1:0]      tx_slew_o,
    output logic            local_rf_o,
    output logic            full_duplex_o,
    output logic            power_down_o,
    output logic            nego_burst_en_o,
    output logic            mii_rate100_o,
    output logic            mlt3_mode_o,
    output logic            manchester_mode_o
);
    // ==========================================================
    // state
    logic [2:0] mdc_s;
    logic [1:0] mdio_s;
    logic [1:0] astrap_s1, astrap_s2;
    logic [2:0] cstrap_s1, cstrap_s2;
    phy_mgmt_pkg::mgmt_state_t state, next_state;
    logic [5:0]  cnt, next_cnt;
    logic [15:0] sh, next_sh;
    logic [15:0] rsh, next_rsh;
    logic [4:0]  regad, next_regad;
    logic        drv, next_drv, drv_oe, next_drv_oe;
    logic        strap_done, next_strap_done;
    logic [1:0]  strap_wait, next_strap_wait;
    logic [4:0]  phy_addr, next_phy_addr;
    logic [2:0]  strap_cfg, next_strap_cfg;
    phy_mgmt_pkg::ctl_t ctl, next_ctl;
    logic [3:0]  abil, next_abil;
    logic        adv_rf, next_adv_rf, st_rf, next_st_rf, lp_rf, next_lp_rf;
    logic        hi_drive, next_hi_drive;
    logic [1:0]  slew, next_slew;
    logic        rise, bitv, commit;
    logic [11:0] hdr;
    logic [15:0] wdata;
    logic        speed_eff, link_up;

    // defaults derived from the configuration straps
    function automatic phy_mgmt_pkg::ctl_t strap_ctl(input logic [2:0] c);
        phy_mgmt_pkg::ctl_t r;
        r.soft_reset  = 1'b0;
        r.power_down  = 1'b0;
        r.an_enable   = c[0];
        r.speed100    = c[0] | c[1];
        r.full_duplex = c[0] | c[2];
        return r;
    endfunction

    // read multiplexer, unmapped registers read zero
    function automatic logic [15:0] rd_word(input logic [4:0] ra);
        logic [15:0] w;
        w = 16'h0000;
        unique case (ra)
            phy_mgmt_pkg::REG_CONTROL: begin
                w[phy_mgmt_pkg::BIT_SOFT_RESET] = ctl.soft_reset;
                w[phy_mgmt_pkg::BIT_SPEED100]   = ctl.speed100;
                w[phy_mgmt_pkg::BIT_AN_ENABLE]  = ctl.an_enable;
                w[phy_mgmt_pkg::BIT_POWER_DOWN] = ctl.power_down;
                w[phy_mgmt_pkg::BIT_DUPLEX]     = ctl.full_duplex;
            end
            phy_mgmt_pkg::REG_STATUS: begin
                w = phy_mgmt_pkg::STATUS_FIXED;
                w[phy_mgmt_pkg::BIT_STAT_RF] = st_rf;
            end
            phy_mgmt_pkg::REG_ADVERT: begin
                w[4:0] = phy_mgmt_pkg::SELECTOR;
                w[phy_mgmt_pkg::BIT_ABIL_LO +: 4] = abil;
                w[phy_mgmt_pkg::BIT_REMOTE_RF]    = adv_rf;
            end
            phy_mgmt_pkg::REG_PARTNER: w[phy_mgmt_pkg::BIT_REMOTE_RF] = lp_rf;
            phy_mgmt_pkg::REG_DRIVE:   w[phy_mgmt_pkg::BIT_HI_DRIVE] = hi_drive;
            phy_mgmt_pkg::REG_TXCTL:   w[phy_mgmt_pkg::BIT_SLEW_LO +: 2] = slew;
            default:                   w = 16'h0000;
        endcase
        return w;
    endfunction

    // ==========================================================
    // frame engine and register file next values
    always_comb begin
        rise  = mdc_s[1] & ~mdc_s[2];
        bitv  = mdio_s[1];
        hdr   = {sh[10:0], bitv};
        wdata = {sh[14:0], bitv};
        commit = 1'b0;
        next_state = state;
        next_cnt = cnt;
        next_sh = sh;
        next_rsh = rsh;
        next_regad = regad;
        next_drv = drv;
        next_drv_oe = drv_oe;
        next_strap_wait = strap_wait;
        next_strap_done = strap_done;
        next_phy_addr = phy_addr;
        next_strap_cfg = strap_cfg;
        next_ctl = ctl;
        next_abil = abil;
        next_adv_rf = adv_rf;
        next_st_rf = st_rf;
        next_lp_rf = lp_rf;
        next_hi_drive = hi_drive;
        next_slew = slew;
        // straps are caught once the synchronisers hold the pin levels, not their reset zeros
        if (!strap_done) begin
            next_strap_wait = strap_wait + 2'h1;
            if (strap_wait == phy_mgmt_pkg::STRAP_SETTLE) begin
                next_strap_wait = strap_wait;
                next_strap_done = 1'b1;
                unique case (astrap_s2)
                    2'h0:    next_phy_addr = phy_mgmt_pkg::ADDR_S0;
                    2'h1:    next_phy_addr = phy_mgmt_pkg::ADDR_S1;
                    2'h2:    next_phy_addr = phy_mgmt_pkg::ADDR_S2;
                    default: next_phy_addr = phy_mgmt_pkg::ADDR_S3;
                endcase
                next_strap_cfg = cstrap_s2;
                next_ctl = strap_ctl(cstrap_s2);
                next_abil = cstrap_s2[2] ? phy_mgmt_pkg::ABIL_ALL : phy_mgmt_pkg::ABIL_HALF;
            end
        end else if (ctl.soft_reset) begin
            next_ctl = strap_ctl(strap_cfg);
            next_abil = strap_cfg[2] ? phy_mgmt_pkg::ABIL_ALL : phy_mgmt_pkg::ABIL_HALF;
            next_adv_rf = 1'b0;
            next_hi_drive = 1'b0;
            next_slew = phy_mgmt_pkg::SLEW_RESET;
        end
        if (rise && strap_done) begin
            unique case (state)
                phy_mgmt_pkg::ST_PRE: begin
                    if (bitv) begin
                        if (cnt != phy_mgmt_pkg::PREAMBLE_LEN) next_cnt = cnt + 6'h01;
                    end else if (cnt == phy_mgmt_pkg::PREAMBLE_LEN) begin
                        next_state = phy_mgmt_pkg::ST_START;
                    end else begin
                        next_cnt = 6'h00;
                    end
                end
                phy_mgmt_pkg::ST_START: begin
                    next_cnt = 6'h00;
                    next_state = bitv ? phy_mgmt_pkg::ST_HDR : phy_mgmt_pkg::ST_PRE;
                end
                phy_mgmt_pkg::ST_HDR: begin
                    next_sh = wdata;
                    next_cnt = cnt + 6'h01;
                    if (cnt == phy_mgmt_pkg::HDR_LAST) begin
                        next_cnt = 6'h00;
                        next_regad = hdr[4:0];
                        next_state = phy_mgmt_pkg::ST_PRE;
                        if (hdr[9:5] == phy_addr && hdr[11:10] == phy_mgmt_pkg::OP_READ) begin
                            next_state = phy_mgmt_pkg::ST_RD_TA;
                            next_rsh = rd_word(hdr[4:0]);
                            // latched fault bits clear on read
                            if (hdr[4:0] == phy_mgmt_pkg::REG_STATUS) next_st_rf = 1'b0;
                            if (hdr[4:0] == phy_mgmt_pkg::REG_PARTNER) next_lp_rf = 1'b0;
                        end
                        if (hdr[9:5] == phy_addr && hdr[11:10] == phy_mgmt_pkg::OP_WRITE)
                            next_state = phy_mgmt_pkg::ST_WR_TA;
                    end
                end
                phy_mgmt_pkg::ST_WR_TA: begin
                    next_cnt = cnt + 6'h01;
                    if (cnt == phy_mgmt_pkg::TA_LAST) begin
                        next_cnt = 6'h00;
                        next_state = phy_mgmt_pkg::ST_WR_DATA;
                    end
                end
                phy_mgmt_pkg::ST_WR_DATA: begin
                    next_sh = wdata;
                    next_cnt = cnt + 6'h01;
                    if (cnt == phy_mgmt_pkg::DATA_LAST) begin
                        commit = 1'b1;
                        next_cnt = 6'h00;
                        next_state = phy_mgmt_pkg::ST_PRE;
                    end
                end
                phy_mgmt_pkg::ST_RD_TA: begin
                    next_drv_oe = 1'b1; // second turnaround bit driven low
                    next_drv = 1'b0;
                    next_cnt = 6'h00;
                    next_state = phy_mgmt_pkg::ST_RD_DATA;
                end
                phy_mgmt_pkg::ST_RD_DATA: begin
                    next_cnt = cnt + 6'h01;
                    if (cnt == phy_mgmt_pkg::DATA_DONE) begin
                        next_drv_oe = 1'b0;
                        next_cnt = 6'h00;
                        next_state = phy_mgmt_pkg::ST_PRE;
                    end else begin
                        next_drv = rsh[15];
                        next_rsh = {rsh[14:0], 1'b0};
                    end
                end
                default: begin
                    next_drv_oe = 1'b0;
                    next_cnt = 6'h00;
                    next_state = phy_mgmt_pkg::ST_PRE;
                end
            endcase
        end
        // register writes
        if (commit) begin
            unique case (regad)
                phy_mgmt_pkg::REG_CONTROL: begin
                    next_ctl.soft_reset  = wdata[phy_mgmt_pkg::BIT_SOFT_RESET];
                    next_ctl.speed100    = wdata[phy_mgmt_pkg::BIT_SPEED100];
                    next_ctl.an_enable   = wdata[phy_mgmt_pkg::BIT_AN_ENABLE];
                    next_ctl.power_down  = wdata[phy_mgmt_pkg::BIT_POWER_DOWN];
                    next_ctl.full_duplex = wdata[phy_mgmt_pkg::BIT_DUPLEX];
                end
                phy_mgmt_pkg::REG_ADVERT: begin
                    next_adv_rf = wdata[phy_mgmt_pkg::BIT_REMOTE_RF];
                    next_abil = wdata[phy_mgmt_pkg::BIT_ABIL_LO +: 4];
                end
                phy_mgmt_pkg::REG_DRIVE: next_hi_drive = wdata[phy_mgmt_pkg::BIT_HI_DRIVE];
                phy_mgmt_pkg::REG_TXCTL: next_slew = wdata[phy_mgmt_pkg::BIT_SLEW_LO +: 2];
                default: ;
            endcase
        end
        // partner fault event wins over a clear by read
        if (partner_rf_i && ctl.an_enable) begin
            next_st_rf = 1'b1;
            next_lp_rf = 1'b1;
        end
        // resolved operating conditions
        speed_eff = ctl.an_enable ? resolved_speed100_i : ctl.speed100;
        link_up = ~ctl.an_enable | resolved_valid_i;
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mdc_s <= 3'h0;
            mdio_s <= 2'h0;
            astrap_s1 <= 2'h0;
            astrap_s2 <= 2'h0;
            cstrap_s1 <= 3'h0;
            cstrap_s2 <= 3'h0;
            state <= phy_mgmt_pkg::ST_PRE;
            cnt <= 6'h00;
            sh <= 16'h0000;
            rsh <= 16'h0000;
            regad <= 5'h00;
            drv <= 1'b0;
            drv_oe <= 1'b0;
            strap_done <= 1'b0;
            strap_wait <= 2'h0;
            phy_addr <= 5'h00;
            strap_cfg <= 3'h0;
            ctl <= '0;
            abil <= 4'h0;
            adv_rf <= 1'b0;
            st_rf <= 1'b0;
            lp_rf <= 1'b0;
            hi_drive <= 1'b0;
            slew <= phy_mgmt_pkg::SLEW_RESET;
            mdio_o <= 1'b0;
            mdio_oe_o <= 1'b0;
            mii_high_drive_o <= 1'b0;
            tx_slew_o <= 2'h0;
            local_rf_o <= 1'b0;
            full_duplex_o <= 1'b0;
            power_down_o <= 1'b0;
            nego_burst_en_o <= 1'b0;
            mii_rate100_o <= 1'b0;
            mlt3_mode_o <= 1'b0;
            manchester_mode_o <= 1'b0;
        end else if (ce_i) begin
            mdc_s <= {mdc_s[1:0], mdc_i};
            mdio_s <= {mdio_s[0], mdio_i};
            astrap_s1 <= addr_strap_i;
            astrap_s2 <= astrap_s1;
            cstrap_s1 <= cfg_strap_i;
            cstrap_s2 <= cstrap_s1;
            state <= next_state;
            cnt <= next_cnt;
            sh <= next_sh;
            rsh <= next_rsh;
            regad <= next_regad;
            drv <= next_drv;
            drv_oe <= next_drv_oe;
            strap_done <= next_strap_done;
            strap_wait <= next_strap_wait;
            phy_addr <= next_phy_addr;
            strap_cfg <= next_strap_cfg;
            ctl <= next_ctl;
            abil <= next_abil;
            adv_rf <= next_adv_rf;
            st_rf <= next_st_rf;
            lp_rf <= next_lp_rf;
            hi_drive <= next_hi_drive;
            slew <= next_slew;
            mdio_o <= next_drv;
            mdio_oe_o <= next_drv_oe;
            mii_high_drive_o <= hi_drive;
            tx_slew_o <= slew;
            local_rf_o <= adv_rf;
            full_duplex_o <= ctl.full_duplex;
            power_down_o <= ctl.power_down;
            nego_burst_en_o <= ctl.an_enable & ~resolved_valid_i & ~ctl.power_down;
            mii_rate100_o <= speed_eff;
            mlt3_mode_o <= link_up & speed_eff & ~ctl.power_down;
            manchester_mode_o <= link_up & ~speed_eff & ~ctl.power_down;
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_addr_strap: assert property (strap_done |-> (phy_addr == 5'h00 || phy_addr == 5'h01 ||
        phy_addr == 5'h1c || phy_addr == 5'h1d)) else $error("bad strapped address");
    a_turn_drive: assert property (ce_i && rise && strap_done && state == phy_mgmt_pkg::ST_RD_TA
        |=> mdio_oe_o && !mdio_o) else $error("turnaround not driven low");
    a_quiet_header: assert property (state == phy_mgmt_pkg::ST_HDR |-> !mdio_oe_o)
        else $error("pin driven during header");
    a_fault_set: assert property (ce_i && partner_rf_i && ctl.an_enable |=> st_rf && lp_rf)
        else $error("remote fault not latched");
    a_adv_fault: assert property (ce_i && commit && regad == phy_mgmt_pkg::REG_ADVERT
        ##1 ce_i |=> local_rf_o == $past(wdata[13], 2)) else $error("local fault lost");
    a_drive_write: assert property (ce_i && commit && regad == phy_mgmt_pkg::REG_DRIVE
        ##1 ce_i |=> mii_high_drive_o == $past(wdata[11], 2)) else $error("drive lost");
    a_nego_burst: assert property (ce_i && ctl.an_enable && !resolved_valid_i && !ctl.power_down
        |=> nego_burst_en_o) else $error("no negotiation bursts");
    a_mode_excl: assert property (!(mlt3_mode_o && manchester_mode_o))
        else $error("both line codings on");
    a_rate_follow: assert property (ce_i && ctl.an_enable |=> mii_rate100_o ==
        $past(resolved_speed100_i)) else $error("MII rate not resolved");
    a_slew_write: assert property (ce_i && commit && regad == phy_mgmt_pkg::REG_TXCTL
        ##1 ce_i |=> tx_slew_o == $past(wdata[11:10], 2)) else $error("slew lost");
    a_soft_reset: assert property (ce_i && strap_done && ctl.soft_reset |=>
        !ctl.soft_reset && ctl.an_enable == strap_cfg[0]) else $error("soft reset");

    c_read_frame: cover property (state == phy_mgmt_pkg::ST_RD_DATA && cnt == 6'h10);
    c_write_frame: cover property (commit);
    c_fault_event: cover property (partner_rf_i && ctl.an_enable);
endmodule

// ===== logic/phy_mgmt_pkg.sv
package phy_mgmt_pkg;
    // ==========================================================
    // register numbers
    localparam logic [4:0] REG_CONTROL = 5'h00;
    localparam logic [4:0] REG_STATUS  = 5'h01;
    localparam logic [4:0] REG_ADVERT  = 5'h04;
    localparam logic [4:0] REG_PARTNER = 5'h05;
    localparam logic [4:0] REG_DRIVE   = 5'h1a;
    localparam logic [4:0] REG_TXCTL   = 5'h1e;
    // ==========================================================
    // bit positions
    localparam int BIT_SOFT_RESET = 15;
    localparam int BIT_SPEED100   = 13;
    localparam int BIT_AN_ENABLE  = 12;
    localparam int BIT_POWER_DOWN = 11;
    localparam int BIT_DUPLEX     = 8;
    localparam int BIT_STAT_RF    = 4;
    localparam int BIT_REMOTE_RF  = 13;
    localparam int BIT_ABIL_LO    = 5;
    localparam int BIT_HI_DRIVE   = 11;
    localparam int BIT_SLEW_LO    = 10;
    // ==========================================================
    // fixed values and reset values
    localparam logic [15:0] STATUS_FIXED = 16'h7809;
    localparam logic [4:0]  SELECTOR     = 5'h01;
    localparam logic [3:0]  ABIL_ALL     = 4'hf;
    localparam logic [3:0]  ABIL_HALF    = 4'h5;
    localparam logic [1:0]  SLEW_RESET   = 2'h0;
    localparam logic [4:0]  ADDR_S0      = 5'h00;
    localparam logic [4:0]  ADDR_S1      = 5'h01;
    localparam logic [4:0]  ADDR_S2      = 5'h1c;
    localparam logic [4:0]  ADDR_S3      = 5'h1d;
    localparam logic [1:0]  STRAP_SETTLE = 2'h2; // edges until the strap synchronisers are full
    // ==========================================================
    // frame layout
    localparam logic [1:0] OP_WRITE     = 2'h1;
    localparam logic [1:0] OP_READ      = 2'h2;
    localparam logic [5:0] PREAMBLE_LEN = 6'h20;
    localparam logic [5:0] HDR_LAST     = 6'h0b;
    localparam logic [5:0] TA_LAST      = 6'h01;
    localparam logic [5:0] DATA_LAST    = 6'h0f;
    localparam logic [5:0] DATA_DONE    = 6'h10;

    typedef enum logic [2:0] {
        ST_PRE     = 3'b000,
        ST_START   = 3'b001,
        ST_HDR     = 3'b010,
        ST_WR_TA   = 3'b011,
        ST_WR_DATA = 3'b100,
        ST_RD_TA   = 3'b101,
        ST_RD_DATA = 3'b110
    } mgmt_state_t;

    typedef struct packed {
        logic       soft_reset;
        logic       speed100;
        logic       an_enable;
        logic       power_down;
        logic       full_duplex;
    } ctl_t;
endpackage

// ===== tb/mdio_host_model.sv
`timescale 1ns/1ns
// ==========================================================
// station management controller: drives management clock and data
module mdio_host_model (
    // clock and resolved pin level
    input  wire logic clk_i,
    input  wire logic pin_i,
    // controller side of the pin
    output logic      mdc_o,
    output logic      drive_o,
    output logic      bit_o
);
    // management clock idles low and the data line is released between frames
    initial begin
        mdc_o   = 1'b0;
        drive_o = 1'b0;
        bit_o   = 1'b1;
    end

    // one clock period of 8 system clocks (800 ns), pin sampled at the rise
    task automatic clk_bit(input logic drv, input logic b, output logic s);
        mdc_o   <= 1'b0;
        drive_o <= drv;
        bit_o   <= b;
        repeat (4) @(posedge clk_i);
        s = pin_i;
        mdc_o <= 1'b1;
        repeat (4) @(posedge clk_i);
    endtask

    // whole frame: preamble, start, opcode, addresses, turnaround, data
    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] regn,
                         input logic [15:0] wdata, output logic [15:0] rdata,
                         output logic ta2);
        logic [13:0] hdr;
        logic        s;
        int          i;
        hdr = {2'h1, op, phy, regn};
        for (i = 0; i < 32; i++) clk_bit(1'b1, 1'b1, s);
        for (i = 13; i >= 0; i--) clk_bit(1'b1, hdr[i], s);
        if (op == phy_mgmt_pkg::OP_READ) begin
            clk_bit(1'b0, 1'b1, s);
            clk_bit(1'b0, 1'b1, ta2);
            for (i = 15; i >= 0; i--) begin
                clk_bit(1'b0, 1'b1, s);
                rdata[i] = s;
            end
        end else begin
            ta2   = 1'b0;
            rdata = 16'h0000;
            clk_bit(1'b1, 1'b1, s);
            clk_bit(1'b1, 1'b0, s);
            for (i = 15; i >= 0; i--) clk_bit(1'b1, wdata[i], s);
        end
        mdc_o   <= 1'b0;
        drive_o <= 1'b0;
        @(posedge clk_i);
    endtask
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ns
`define CHK(got, exp) begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
end
module tb;
    // ==========================================================
    // signals
    logic        clk, rst_n, ce, mdc, host_drive, host_bit, mdio_wire, dut_mdio, dut_oe;
    logic [1:0]  addr_strap, slew;
    logic [2:0]  cfg_strap;
    logic        partner_rf, res_valid, res_speed, high_drive, local_rf, full_dup, pdn;
    logic        nego_en, rate100, mlt3, manch, an, sp, dp;
    logic [4:0]  phy, exp5;
    logic [3:0]  abil_e;
    logic [2:0]  cfgs [4] = '{3'h0, 3'h6, 3'h3, 3'h5};
    logic [4:0]  addrs [4] = '{5'h00, 5'h01, 5'h1c, 5'h1d};
    int          k, cycles, mismatches, total_checks;

    // shared data line, the DUT drive wins over the host, pull-up when both release
    assign mdio_wire = dut_oe ? dut_mdio : (host_drive ? host_bit : 1'b1);

    phy_mgmt_and_link_config phy_mgmt_and_link_config_i (
        .clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .mdc_i(mdc), .mdio_i(mdio_wire),
        .mdio_o(dut_mdio), .mdio_oe_o(dut_oe), .addr_strap_i(addr_strap),
        .cfg_strap_i(cfg_strap), .partner_rf_i(partner_rf), .resolved_valid_i(res_valid),
        .resolved_speed100_i(res_speed), .mii_high_drive_o(high_drive), .tx_slew_o(slew),
        .local_rf_o(local_rf), .full_duplex_o(full_dup), .power_down_o(pdn),
        .nego_burst_en_o(nego_en), .mii_rate100_o(rate100), .mlt3_mode_o(mlt3),
        .manchester_mode_o(manch)
    );

    mdio_host_model mdio_host_model_i (
        .clk_i(clk), .pin_i(mdio_wire), .mdc_o(mdc), .drive_o(host_drive), .bit_o(host_bit)
    );

    // ==========================================================
    // access tasks
    task automatic report_and_stop();
        if (mismatches == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // write, then let the register and its output settle
    task automatic wr(input logic [4:0] r, input logic [15:0] d);
        logic [15:0] q;
        logic        t;
        mdio_host_model_i.frame(phy_mgmt_pkg::OP_WRITE, phy, r, d, q, t);
        repeat (3) @(posedge clk);
    endtask

    // read and compare turnaround bit and data together
    task automatic rd(input logic [4:0] r, input logic [16:0] e);
        logic [15:0] q;
        logic        t;
        mdio_host_model_i.frame(phy_mgmt_pkg::OP_READ, phy, r, 16'h0000, q, t);
        `CHK({t, q}, e)
    endtask

    // ==========================================================
    // clock and watchdog
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            report_and_stop();
        end
    end

    // ==========================================================
    // test sequence
    initial begin
        rst_n = 1'b0; ce = 1'b1; addr_strap = 2'h0; cfg_strap = 3'h0; partner_rf = 1'b0;
        res_valid = 1'b0; res_speed = 1'b0; phy = 5'h00;
        cycles = 0; mismatches = 0; total_checks = 0;
        // every address strap, each with its own configuration strap set
        for (k = 0; k < 4; k++) begin
            @(posedge clk);
            addr_strap <= k[1:0];
            cfg_strap  <= cfgs[k];
            rst_n      <= 1'b0;
            repeat (5) @(posedge clk);
            rst_n <= 1'b1;
            repeat (4) @(posedge clk);
            phy = addrs[k];
            an = cfgs[k][0];
            sp = an | cfgs[k][1];
            dp = an | cfgs[k][2];
            rd(phy_mgmt_pkg::REG_CONTROL, {3'h0, sp, an, 3'h0, dp, 8'h00});
            rd(phy_mgmt_pkg::REG_STATUS, 17'h0_7809);
            exp5 = {dp, an, ~an & sp, ~an & ~sp, ~an & sp};
            `CHK({full_dup, nego_en, mlt3, manch, rate100}, exp5)
            abil_e = cfgs[k][2] ? phy_mgmt_pkg::ABIL_ALL : phy_mgmt_pkg::ABIL_HALF;
            if (an) begin
                rd(phy_mgmt_pkg::REG_ADVERT, {8'h00, abil_e, phy_mgmt_pkg::SELECTOR});
            end
        end
        // a foreign address gets no answer and cannot write
        phy = 5'h1f;
        rd(phy_mgmt_pkg::REG_STATUS, 17'h1_ffff);
        wr(phy_mgmt_pkg::REG_DRIVE, 16'h0800);
        `CHK(high_drive, 1'b0)
        phy = 5'h1d;
        wr(phy_mgmt_pkg::REG_DRIVE, 16'h0800);
        `CHK(high_drive, 1'b1)
        rd(phy_mgmt_pkg::REG_DRIVE, 17'h0_0800);
        rd(5'h1f, 17'h0_0000);
        // partner fault event latches in two places, cleared by reading
        @(posedge clk);
        partner_rf <= 1'b1;
        @(posedge clk);
        partner_rf <= 1'b0;
        rd(phy_mgmt_pkg::REG_PARTNER, 17'h0_2000);
        rd(phy_mgmt_pkg::REG_STATUS, 17'h0_7819);
        rd(phy_mgmt_pkg::REG_STATUS, 17'h0_7809);
        // local fault advertised to the partner
        wr(phy_mgmt_pkg::REG_ADVERT, 16'h21e1);
        `CHK(local_rf, 1'b1)
        rd(phy_mgmt_pkg::REG_ADVERT, 17'h0_21e1);
        // all four slew settings
        for (k = 0; k < 4; k++) begin
            wr(phy_mgmt_pkg::REG_TXCTL, {4'h0, k[1:0], 10'h000});
            `CHK(slew, k[1:0])
        end
        // resolved link picks rate and line coding
        @(posedge clk);
        res_valid <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK({nego_en, rate100, mlt3, manch}, 4'h1)
        res_speed <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK({nego_en, rate100, mlt3, manch}, 4'h6)
        // power down silences both line codings and the pulse bursts
        wr(phy_mgmt_pkg::REG_CONTROL, 16'h3900);
        `CHK({pdn, nego_en, mlt3, manch}, 4'h8)
        // soft reset returns to the strap defaults
        wr(phy_mgmt_pkg::REG_CONTROL, 16'h8000);
        `CHK({pdn, high_drive, slew, local_rf}, 5'h00)
        rd(phy_mgmt_pkg::REG_CONTROL, 17'h0_3100);
        report_and_stop();
    end
endmodule
